// *** msm_mapper.sv ***
// What this block does
// - reset selects standard code mapping: only flash is reachable in code space
// - unified bit set maps flash, sram and registers into code space
// - flash above 32 KB: xdata 0x0000-0xDEFF maps to first 56 KB flash
// - 32 KB flash: whole flash sits at xdata 0x0000-0x7FFF
// - 32 KB flash: unimplemented regions give an undefined result
// - sram of 8 KB sits at xdata 0xE000-0xFFFF on every option
// - xdata 0xDF80-0xDFFF goes to the sfr file
// - xdata 0xDF00-0xDF7F goes to the radio register area
// - bank select never changes the xdata view of flash
// - sfr space holds 128 bytes; multiples of eight are bit addressable
// - code and xdata share one bus; a fetch waits for xdata access
// - unified code above 0xDEFF returns no flash content
// - unified code space reaches the sram so code can run there
// - 128 KB flash: upper 32 KB code banked over four banks, lower fixed
// - bank select lives behind two aliased register locations
// - banking plus unified mapping exposes only lowest 24 KB of bank
// - data space is the top 256 sram bytes, also at 0xFF00-0xFFFF
// - core-internal sfrs are not reachable through the xdata window
// - core-internal sfrs are not reachable through unified code space
// - sram 0xF000-0xFFFF retains in deep low-power modes, minus exclusions
`timescale 1ns/1ps
`include "msm_defs.svh"

module msm_mapper
  import msm_pkg::*;
#(
  parameter int FLASH_KB = 128,
  parameter logic [127:0] CORE_SFR_MASK = `MSM_CORE_SFR_MASK
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // instruction fetch from the core
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  output logic fetch_ready,
  // data access from the core or dma
  input msm_req_t data_req,
  output logic data_ready,
  // shared code/xdata bus toward the memories
  output msm_acc_t bus_acc,
  // internal data/sfr port toward sram and sfr file
  output msm_acc_t int_acc,
  // mapping register readback
  output logic map_rd_hit,
  output logic [7:0] map_rdata,
  // mapping state for the rest of the chip
  output logic unified_code_map_select,
  output logic [1:0] flash_bank_sel
);

  // ----------------------------------------------------------------
  // option flags
  // ----------------------------------------------------------------
  localparam logic FLASH_BIG = (FLASH_KB > 32);
  localparam logic FLASH_BANKED = (FLASH_KB == 128);

  // ----------------------------------------------------------------
  // region helpers
  // ----------------------------------------------------------------
  function automatic logic is_core_sfr(input logic [6:0] idx);
    is_core_sfr = CORE_SFR_MASK[idx];
  endfunction : is_core_sfr

  function automatic logic retained_at(input logic [15:0] a);
    logic in_win;
    logic in_excl;
    in_win = (a >= `MSM_RETAIN_BASE);
    in_excl = (a >= `MSM_NORET_LO) && (a <= `MSM_NORET_HI);
    retained_at = in_win && !in_excl;
  endfunction : retained_at

  // ----------------------------------------------------------------
  // decoder: pure function of space, address and mapping state
  // ----------------------------------------------------------------
  function automatic msm_resp_t decode(
    input msm_space_t sp,
    input logic [15:0] a,
    input logic unif,
    input logic [1:0] bk
  );
    msm_resp_t r;
    logic lo_half;
    logic up_flash;
    logic in_radio;
    logic in_sfrw;
    logic in_sram;
    logic [1:0] bank_eff;
    logic [6:0] widx;
    r = '0;
    r.target = TGT_NONE;
    lo_half = (a <= `MSM_FLASH_LO_END);
    up_flash = !lo_half && (a <= `MSM_XD_FLASH_END);
    in_radio = (a >= `MSM_RADIO_BASE) && (a <= `MSM_RADIO_END);
    in_sfrw = (a >= `MSM_SFR_WIN_BASE) && (a <= `MSM_SFR_WIN_END);
    in_sram = (a >= `MSM_SRAM_BASE);
    widx = a[6:0];
    // 64 KB parts have one fixed upper bank
    bank_eff = FLASH_BANKED ? bk : 2'h1;
    unique case (sp)
      SPACE_XDATA: begin
        if (lo_half) begin
          r.target = TGT_FLASH;
          r.flash_addr = {1'b0, a};
        end else if (up_flash && FLASH_BIG) begin
          // fixed flash, bank select deliberately ignored
          r.target = TGT_FLASH;
          r.flash_addr = {1'b0, a};
        end else if (in_radio) begin
          r.target = TGT_RADIO;
          r.reg_addr = widx;
        end else if (in_sfrw) begin
          r.target = is_core_sfr(widx) ? TGT_NONE : TGT_SFR;
          r.reg_addr = widx;
        end else if (in_sram) begin
          r.target = TGT_SRAM;
          r.sram_addr = a[12:0];
          r.retained = retained_at(a);
        end
        // anything left on a 32 KB part stays undefined
      end
      SPACE_CODE: begin
        if (lo_half) begin
          r.target = TGT_FLASH;
          r.flash_addr = {2'h0, a[14:0]};
        end else if (!unif) begin
          if (FLASH_BIG) begin
            r.target = TGT_FLASH;
            r.flash_addr = {bank_eff, a[14:0]};
          end
        end else if (up_flash) begin
          if (FLASH_BIG) begin
            // only the lowest 24 KB of the bank fits below the registers
            r.target = TGT_FLASH;
            r.flash_addr = {bank_eff, a[14:0]};
          end
        end else if (in_radio) begin
          r.target = TGT_RADIO;
          r.reg_addr = widx;
        end else if (in_sfrw) begin
          r.target = is_core_sfr(widx) ? TGT_NONE : TGT_SFR;
          r.reg_addr = widx;
        end else if (in_sram) begin
          r.target = TGT_SRAM;
          r.sram_addr = a[12:0];
          r.retained = retained_at(a);
        end
      end
      SPACE_DATA: begin
        r.target = TGT_SRAM;
        r.sram_addr = `MSM_DATA_SRAM_BASE | {5'h00, a[7:0]};
        r.retained = retained_at({8'hFF, a[7:0]});
      end
      SPACE_SFR: begin
        // the upper half of an 8-bit direct address
        r.target = is_core_sfr(a[6:0]) ? TGT_CORE : TGT_SFR;
        r.reg_addr = a[6:0];
      end
      SPACE_BIT: begin
        r.bit_op = 1'b1;
        r.bit_idx = a[2:0];
        if (a[7:0] >= `MSM_BIT_SFR_LIMIT) begin
          r.target = is_core_sfr({a[6:3], 3'h0}) ? TGT_CORE : TGT_SFR;
          r.reg_addr = {a[6:3], 3'h0};
        end else begin
          r.target = TGT_SRAM;
          r.sram_addr = `MSM_BIT_DATA_BASE | {9'h000, a[6:3]};
          r.retained = 1'b1;
        end
      end
      default: begin
        r.target = TGT_NONE;
      end
    endcase
    decode = r;
  endfunction : decode

  // ----------------------------------------------------------------
  // mapping state
  // ----------------------------------------------------------------
  logic unif;
  logic [1:0] bank;
  logic [7:0] ctrl_rd;
  logic [7:0] bank_rd;
  logic ctrl_we;
  logic bank_we;

  // ----------------------------------------------------------------
  // arbitration of the shared code/xdata bus
  // ----------------------------------------------------------------
  wire data_on_bus = data_req.valid &&
                     (data_req.space == SPACE_XDATA || data_req.space == SPACE_CODE);
  wire data_on_int = data_req.valid && !data_on_bus;

  // a fetch cannot overlap an xdata or movc access, so it waits
  assign fetch_ready = !data_on_bus;
  assign data_ready = 1'b1;

  wire msm_space_t bus_space = data_on_bus ? data_req.space : SPACE_CODE;
  wire [15:0] bus_addr = data_on_bus ? data_req.addr : fetch_addr;
  wire bus_valid = data_on_bus || fetch_valid;

  // ----------------------------------------------------------------
  // decode both ports
  // ----------------------------------------------------------------
  wire msm_resp_t bus_resp = decode(bus_space, bus_addr, unif, bank);
  wire msm_resp_t int_resp = decode(data_req.space, data_req.addr, unif, bank);

  always_comb begin
    bus_acc.valid = bus_valid;
    bus_acc.from_fetch = !data_on_bus && fetch_valid;
    bus_acc.write = data_on_bus && data_req.write && data_req.space == SPACE_XDATA;
    bus_acc.wdata = data_req.wdata;
    bus_acc.resp = bus_resp;
    int_acc.valid = data_on_int;
    int_acc.from_fetch = 1'b0;
    int_acc.write = data_on_int && data_req.write;
    int_acc.wdata = data_req.wdata;
    int_acc.resp = int_resp;
  end

  // ----------------------------------------------------------------
  // snoop writes to the two mapping registers on either port
  // ----------------------------------------------------------------
  wire bus_sfr = bus_acc.valid && bus_resp.target == TGT_SFR;
  wire int_sfr = int_acc.valid && int_resp.target == TGT_SFR && !int_resp.bit_op;
  wire bus_ctrl_hit = bus_sfr && bus_resp.reg_addr == `MSM_SFR_MEMCTL;
  wire bus_bank_hit = bus_sfr && bus_resp.reg_addr == `MSM_SFR_BANKMAP;
  wire int_ctrl_hit = int_sfr && int_resp.reg_addr == `MSM_SFR_MEMCTL;
  wire int_bank_hit = int_sfr && int_resp.reg_addr == `MSM_SFR_BANKMAP;

  // both ports carry the same data_req write data, never a fetch
  assign ctrl_we = (bus_ctrl_hit && bus_acc.write) || (int_ctrl_hit && int_acc.write);
  assign bank_we = (bus_bank_hit && bus_acc.write) || (int_bank_hit && int_acc.write);

  msm_map_ctrl u_ctrl (
    .mclk(mclk),
    .reset(reset),
    .ctrl_we(ctrl_we),
    .bank_we(bank_we),
    .wdata(data_req.wdata),
    .unified_code_map_select(unif),
    .bank_sel(bank),
    .memory_control_rd(ctrl_rd),
    .flash_bank_map_rd(bank_rd)
  );

  // ----------------------------------------------------------------
  // readback of the mapping registers
  // ----------------------------------------------------------------
  wire rd_ctrl = ((bus_ctrl_hit && !bus_acc.write) || (int_ctrl_hit && !int_acc.write));
  wire rd_bank = ((bus_bank_hit && !bus_acc.write) || (int_bank_hit && !int_acc.write));

  assign map_rd_hit = rd_ctrl || rd_bank;
  assign map_rdata = rd_ctrl ? ctrl_rd : (rd_bank ? bank_rd : 8'h00);
  assign unified_code_map_select = unif;
  assign flash_bank_sel = bank;

endmodule : msm_mapper

// *** msm_defs.svh ***
`ifndef MSM_DEFS_SVH
`define MSM_DEFS_SVH

// ----------------------------------------------------------------
// address map boundaries
// ----------------------------------------------------------------
`define MSM_FLASH_LO_END 16'h7FFF
`define MSM_XD_FLASH_END 16'hDEFF
`define MSM_RADIO_BASE 16'hDF00
`define MSM_RADIO_END 16'hDF7F
`define MSM_SFR_WIN_BASE 16'hDF80
`define MSM_SFR_WIN_END 16'hDFFF
`define MSM_SRAM_BASE 16'hE000
`define MSM_DATA_SRAM_BASE 13'h1F00
`define MSM_BIT_DATA_BASE 13'h1F20
`define MSM_BIT_SFR_LIMIT 8'h80

// ----------------------------------------------------------------
// retention window of the sram in the deep low-power modes
// ----------------------------------------------------------------
`define MSM_RETAIN_BASE 16'hF000
`define MSM_NORET_LO 16'hFD56
`define MSM_NORET_HI 16'hFEFF

// ----------------------------------------------------------------
// mapping control registers: sfr index (address minus 0x80) and fields
// ----------------------------------------------------------------
`define MSM_SFR_MEMCTL 7'h47
`define MSM_SFR_BANKMAP 7'h1F
`define MSM_MEMCTL_UNIF_BIT 6
`define MSM_MEMCTL_BANK_LSB 4
`define MSM_BANKMAP_LSB 0
`define MSM_CTRL_RESET 8'h00
`define MSM_BANK_RESET 2'h0

// ----------------------------------------------------------------
// sfrs held inside the core, one bit per sfr index
// ----------------------------------------------------------------
`define MSM_CORE_SFR_MASK 128'h00010001_00010000_00000000_0004003E

`endif

// *** msm_pkg.sv ***
package msm_pkg;

  typedef enum logic [4:0] {
    SPACE_CODE = 5'h01,
    SPACE_DATA = 5'h02,
    SPACE_XDATA = 5'h04,
    SPACE_SFR = 5'h08,
    SPACE_BIT = 5'h10
  } msm_space_t;

  typedef enum logic [5:0] {
    TGT_NONE = 6'h01,
    TGT_FLASH = 6'h02,
    TGT_SRAM = 6'h04,
    TGT_SFR = 6'h08,
    TGT_RADIO = 6'h10,
    TGT_CORE = 6'h20
  } msm_target_t;

  typedef struct packed {
    logic valid;
    msm_space_t space;
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
  } msm_req_t;

  typedef struct packed {
    msm_target_t target;
    logic [16:0] flash_addr;
    logic [12:0] sram_addr;
    logic [6:0] reg_addr;
    logic [2:0] bit_idx;
    logic bit_op;
    logic retained;
  } msm_resp_t;

  typedef struct packed {
    logic valid;
    logic from_fetch;
    logic write;
    logic [7:0] wdata;
    msm_resp_t resp;
  } msm_acc_t;

endpackage : msm_pkg

// *** msm_map_ctrl.sv ***
`timescale 1ns/1ps
`include "msm_defs.svh"

module msm_map_ctrl
  import msm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // write strobes from either alias
  input wire logic ctrl_we,
  input wire logic bank_we,
  input wire logic [7:0] wdata,
  // mapping state
  output logic unified_code_map_select,
  output logic [1:0] bank_sel,
  output logic [7:0] memory_control_rd,
  output logic [7:0] flash_bank_map_rd
);

  // ----------------------------------------------------------------
  // storage: one bank field behind two register locations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] bank_q;
  logic [1:0] bank_d;

  assign ctrl_d = ctrl_we ? wdata : ctrl_q;
  // bank map write wins when both aliases are hit in one cycle
  assign bank_d = bank_we ? wdata[`MSM_BANKMAP_LSB +: 2] :
                  ctrl_we ? wdata[`MSM_MEMCTL_BANK_LSB +: 2] : bank_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `MSM_CTRL_RESET;
      bank_q <= `MSM_BANK_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      bank_q <= bank_d;
    end
  end

  // ----------------------------------------------------------------
  // readback, both views show the same bank bits
  // ----------------------------------------------------------------
  logic [7:0] ctrl_view;
  logic [7:0] bank_view;

  always_comb begin
    ctrl_view = ctrl_q;
    ctrl_view[`MSM_MEMCTL_BANK_LSB +: 2] = bank_q;
    bank_view = 8'h00;
    bank_view[`MSM_BANKMAP_LSB +: 2] = bank_q;
  end

  assign unified_code_map_select = ctrl_q[`MSM_MEMCTL_UNIF_BIT];
  assign bank_sel = bank_q;
  assign memory_control_rd = ctrl_view;
  assign flash_bank_map_rd = bank_view;

endmodule : msm_map_ctrl

// *** msm_mapper_checker.sv ***
`timescale 1ns/1ps
module msm_mapper_checker
  import msm_pkg::*;
#(
  parameter int FLASH_KB = 128
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // requests
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input msm_req_t data_req,
  // answers
  input wire logic fetch_ready,
  input wire logic data_ready,
  input msm_acc_t bus_acc,
  input msm_acc_t int_acc,
  input wire logic unified_code_map_select,
  input wire logic [1:0] flash_bank_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire xd = data_req.valid && data_req.space == SPACE_XDATA;
  wire ft = fetch_valid && fetch_ready;
  wire unif = unified_code_map_select;
  msm_resp_t br;
  assign br = bus_acc.resp;

  AST_FETCH_WAIT:
  assert property (xd || (data_req.valid && data_req.space == SPACE_CODE)
    |-> !fetch_ready && !bus_acc.from_fetch) else $error("fetch taken beside data");
  AST_DATA_READY:
  assert property (data_req.valid |-> data_ready) else $error("data access refused");
  AST_XD_SRAM:
  assert property (xd && data_req.addr >= 16'hE000 |-> br.target == TGT_SRAM
    && br.sram_addr == data_req.addr[12:0]) else $error("xdata sram misrouted");
  AST_XD_RADIO:
  assert property (xd && data_req.addr[15:7] == 9'h1BE |-> br.target == TGT_RADIO)
    else $error("radio window misrouted");
  AST_XD_SFR:
  assert property (xd && data_req.addr[15:7] == 9'h1BF
    |-> br.target inside {TGT_SFR, TGT_NONE}) else $error("sfr window misrouted");
  AST_XD_FLASH:
  assert property (xd && data_req.addr <= 16'hDEFF && FLASH_KB > 32
    |-> br.target == TGT_FLASH && br.flash_addr == {1'h0, data_req.addr})
    else $error("xdata flash misrouted");
  AST_ONE_TARGET:
  assert property (bus_acc.valid |-> $onehot(br.target)) else $error("target not one-hot");
  AST_BANK_WRITE:
  assert property (data_req.valid && data_req.write && data_req.space == SPACE_SFR
    && data_req.addr[7:0] == 8'h9F |=> flash_bank_sel == $past(data_req.wdata[1:0]))
    else $error("bank write lost");
  AST_UNIF_SRAM:
  assert property (ft && unif && fetch_addr >= 16'hE000 |-> br.target == TGT_SRAM)
    else $error("unified fetch missed sram");
  AST_STD_FLASH:
  assert property (ft && !unif && FLASH_KB == 128 |-> br.target == TGT_FLASH)
    else $error("standard fetch left flash");
  AST_DATA_TOP:
  assert property (data_req.valid && data_req.space == SPACE_DATA
    |-> int_acc.resp.target == TGT_SRAM
    && int_acc.resp.sram_addr == {5'h1F, data_req.addr[7:0]}) else $error("data misrouted");
  AST_RESET_MAP:
  assert property ($fell(reset) |-> !unif && flash_bank_sel == 2'h0)
    else $error("mapping not cleared");
endmodule : msm_mapper_checker

bind msm_mapper msm_mapper_checker #(.FLASH_KB(FLASH_KB)) u_chk (
  .mclk(mclk), .reset(reset), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .data_req(data_req), .fetch_ready(fetch_ready), .data_ready(data_ready),
  .bus_acc(bus_acc), .int_acc(int_acc),
  .unified_code_map_select(unified_code_map_select), .flash_bank_sel(flash_bank_sel));

// *** msm_cpu_model.sv ***
`timescale 1ns/1ps
module msm_cpu_model
  import msm_pkg::*;
(
  // clock
  mclk,
  // requests toward the mapper
  fetch_valid,
  fetch_addr,
  data_req
);
  input wire logic mclk;
  output logic fetch_valid = 1'h0;
  output logic [15:0] fetch_addr = 16'h0000;
  output msm_req_t data_req = '0;
  // data access held until the next access or fetch; the fetch line is left alone so it can stall
  task automatic access(input msm_space_t sp, input logic [15:0] a, input logic wr,
      input logic [7:0] wd);
    @(posedge mclk);
    data_req <= '{valid: 1'h1, space: sp, addr: a, write: wr, wdata: wd};
  endtask : access
  // a fetch goes out with the data side released, so it is never held off
  task automatic fetch(input logic [15:0] a);
    @(posedge mclk);
    fetch_valid <= 1'h1;
    fetch_addr <= a;
    data_req.valid <= 1'h0;
  endtask : fetch
endmodule : msm_cpu_model

// *** cpu_memory_space_mapper_test.sv ***
`timescale 1ns/1ps
module cpu_memory_space_mapper_test;
  import msm_pkg::*;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic fetch_valid, fetch_ready, data_ready, map_rd_hit, unif;
  logic [15:0] fetch_addr;
  logic [7:0] map_rdata;
  logic [1:0] bank;
  msm_req_t data_req;
  msm_acc_t bus_acc, int_acc;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #10 mclk = ~mclk;
  msm_cpu_model m (.mclk(mclk), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .data_req(data_req));
  msm_mapper #(.FLASH_KB(128)) dut (.mclk(mclk), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .data_req(data_req),
    .data_ready(data_ready), .bus_acc(bus_acc), .int_acc(int_acc), .map_rd_hit(map_rd_hit),
    .map_rdata(map_rdata), .unified_code_map_select(unif), .flash_bank_sel(bank));
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // outputs are looked at mid-cycle, once the launching edge has settled
  task automatic ax(input msm_space_t sp, input logic [15:0] a, input logic wr,
      input logic [7:0] wd);
    m.access(sp, a, wr, wd);
    @(negedge mclk);
  endtask : ax
  task automatic fx(input logic [15:0] a);
    m.fetch(a);
    @(negedge mclk);
  endtask : fx
  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // ----
  // scenarios
  // ----
  task automatic t_reset_map;
    fx(16'hE010);
    chk("unified", 1'h0, unif);
    chk("bank", 2'h0, bank);
    chk("fetch ready", 1'h1, fetch_ready);
    chk("fetch from", 1'h1, bus_acc.from_fetch);
    chk("fetch target", TGT_FLASH, bus_acc.resp.target);
    chk("fetch flash", 17'h06010, bus_acc.resp.flash_addr);
  endtask : t_reset_map
  task automatic t_xdata_map;
    logic [15:0] xa [8] = '{16'h0000, 16'h7FFF, 16'hDEFF, 16'hDF00, 16'hDF7F, 16'hDF80,
      16'hDF81, 16'hFFFF};
    msm_target_t xt [8] = '{TGT_FLASH, TGT_FLASH, TGT_FLASH, TGT_RADIO, TGT_RADIO, TGT_SFR,
      TGT_NONE, TGT_SRAM};
    for (int i = 0; i < 8; i++) begin
      ax(SPACE_XDATA, xa[i], 1'h0, 8'h00);
      chk("xdata target", xt[i], bus_acc.resp.target);
      chk("fetch stall", 1'h0, fetch_ready);
    end
    chk("xdata sram", 13'h1FFF, bus_acc.resp.sram_addr);
    chk("xdata retained", 1'h1, bus_acc.resp.retained);
    ax(SPACE_XDATA, 16'hE000, 1'h0, 8'h00);
    chk("xdata lost low", 1'h0, bus_acc.resp.retained);
    ax(SPACE_XDATA, 16'hFD56, 1'h0, 8'h00);
    chk("xdata lost excl", 1'h0, bus_acc.resp.retained);
  endtask : t_xdata_map
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      if (b[0])
        ax(SPACE_SFR, 16'h009F, 1'h1, {6'h00, b[1:0]});
      else
        ax(SPACE_XDATA, 16'hDFC7, 1'h1, {2'h0, b[1:0], 4'h0});
      chk("bus write", b[0] ? 1'h0 : 1'h1, bus_acc.write);
      chk("int write", b[0] ? 1'h1 : 1'h0, int_acc.write);
      ax(SPACE_SFR, 16'h00C7, 1'h0, 8'h00);
      chk("bank", b, bank);
      chk("ctrl hit", 1'h1, map_rd_hit);
      chk("ctrl bank", b, map_rdata[5:4]);
      ax(SPACE_XDATA, 16'h8010, 1'h0, 8'h00);
      chk("xdata flash", 17'h08010, bus_acc.resp.flash_addr);
      fx(16'h8010);
      chk("code flash", {b[1:0], 15'h0010}, bus_acc.resp.flash_addr);
    end
  endtask : t_banks
  task automatic t_unified;
    ax(SPACE_SFR, 16'h00C7, 1'h1, 8'h60);
    fx(16'hE010);
    chk("unified", 1'h1, unif);
    chk("code sram", TGT_SRAM, bus_acc.resp.target);
    chk("code sram addr", 13'h0010, bus_acc.resp.sram_addr);
    fx(16'hDF81);
    chk("code core", TGT_NONE, bus_acc.resp.target);
    fx(16'hDF00);
    chk("code radio", TGT_RADIO, bus_acc.resp.target);
    fx(16'h8010);
    chk("code bank", 17'h10010, bus_acc.resp.flash_addr);
    fx(16'hFF05);
    chk("code data", 13'h1F05, bus_acc.resp.sram_addr);
  endtask : t_unified
  task automatic t_spaces;
    ax(SPACE_DATA, 16'h0010, 1'h0, 8'h00);
    chk("data target", TGT_SRAM, int_acc.resp.target);
    chk("data sram", 13'h1F10, int_acc.resp.sram_addr);
    chk("data valid", 1'h1, int_acc.valid);
    ax(SPACE_SFR, 16'h0081, 1'h0, 8'h00);
    chk("sfr core", TGT_CORE, int_acc.resp.target);
    ax(SPACE_BIT, 16'h00A3, 1'h0, 8'h00);
    chk("bit target", TGT_SFR, int_acc.resp.target);
    chk("bit reg", 7'h20, int_acc.resp.reg_addr);
    chk("bit idx", 3'h3, int_acc.resp.bit_idx);
    chk("bit op", 1'h1, int_acc.resp.bit_op);
    chk("data ready", 1'h1, data_ready);
  endtask : t_spaces
  // ----
  // main sequence
  // ----
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'h0;
    t_reset_map();
    t_xdata_map();
    t_banks();
    t_unified();
    t_spaces();
    @(posedge mclk);
    reset <= 1'h1;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    t_reset_map();
    print_verdict();
  end
  // a hang is cut short and counted
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule : cpu_memory_space_mapper_test
